/* File: bench/hsc_sink_model.sv */
// Behavioural display that answers capability reads on the DDC wires.
`timescale 1ns/10ps

module hsc_sink_model (
  // DDC wire levels
  input wire logic scl,
  input wire logic sda,
  // Refusal and extension count controls
  input wire logic mute,
  input wire logic [7:0] ext_count,
  // Open-drain pull on the data wire
  output logic sda_pull
);
  logic [7:0] sh, ptr, tx;
  logic act, rd, mack;
  int bitc, nb;

  function automatic logic [7:0] rom(input logic [7:0] i);
    return (i == 8'h7E) ? ext_count : (i ^ 8'h5A);
  endfunction : rom

  initial begin
    sda_pull = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    mack = 1'b1;
    bitc = 0;
    nb = 0;
  end

  // ================================================================
  // Framing: the display only ever answers, it never starts a transfer.
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    // The start's own SCL fall brings the count up to bit zero.
    bitc = -1;
    nb = 0;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end

  always @(posedge scl) if (act) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else mack = sda;
  end

  // ================================================================
  // Data is only ever pulled low or released on the shared wire.
  always @(negedge scl) if (act) begin
    bitc = bitc + 1;
    if (bitc == 8) begin
      sda_pull = !rd && !mute;
      if (nb == 0) rd = sh[0];
      else if (!rd) ptr = sh;
    end else if (bitc == 9) begin
      bitc = 0;
      nb = nb + 1;
      if (rd && !mack) begin
        tx = rom(ptr);
        ptr = ptr + 8'h01;
        sda_pull = !tx[7];
      end else begin
        sda_pull = 1'b0;
      end
    end else if (rd) begin
      sda_pull = !tx[7-bitc];
    end
  end
endmodule : hsc_sink_model

/* File: bench/hsc_top_properties.sv */
// Port-level checks for the HDMI sideband control block.
`timescale 1ns/10ps

module hsc_top_properties #(
  parameter int TMDS_LANES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Watched ports
  input wire logic sink_enable,
  input wire logic ddc_slave_ready,
  input wire logic sink_presence_assert,
  input wire logic hpd_n_pin,
  input wire logic sink_present,
  input wire logic ddc_sda_out,
  input wire logic ddc_sda_oe,
  input wire logic edid_valid,
  input wire logic [7:0] edid_data,
  input wire logic [7:0] edid_index,
  input wire logic query_done,
  input wire logic dvi_only,
  input wire logic video_enable,
  input wire logic [TMDS_LANES-1:0] tmds_lane_en,
  input wire logic cec_src_pull_low,
  input wire logic cec_src_in,
  input wire logic cec_src_out,
  input wire logic cec_src_oe,
  input wire logic cec_src_level
);
  logic [7:0] ext_seen_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ext_seen_r <= 8'h00;
    else if (edid_valid && edid_index == 8'h7E) ext_seen_r <= edid_data;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ================================================================
  // Properties
  property p_pres_on; sink_enable && ddc_slave_ready |=> sink_presence_assert; endproperty
  property p_pres_off; !ddc_slave_ready |=> !sink_presence_assert; endproperty
  property p_drain; !ddc_sda_out && !cec_src_out; endproperty
  property p_cec_oe; 1 |=> cec_src_oe == $past(cec_src_pull_low); endproperty
  property p_plug; !hpd_n_pin [*6] |-> sink_present; endproperty
  property p_cec_lvl; !cec_src_in [*6] |-> !cec_src_level; endproperty
  property p_gate; video_enable |-> query_done && (&tmds_lane_en); endproperty
  property p_dvi; $rose(query_done) |-> sink_present && dvi_only == (ext_seen_r == 8'h00);
  endproperty
  property p_clear; $fell(sink_present) |=> !query_done && !video_enable && !ddc_sda_oe;
  endproperty

  a_pres_on: assert property (p_pres_on)
    else $error("presence not raised");
  a_pres_off: assert property (p_pres_off)
    else $error("presence raised early");
  a_drain: assert property (p_drain)
    else $error("wire driven high");
  a_cec_oe: assert property (p_cec_oe)
    else $error("cec pull mismatch");
  a_plug: assert property (p_plug)
    else $error("plug not seen");
  a_cec_lvl: assert property (p_cec_lvl)
    else $error("cec level stale");
  a_gate: assert property (p_gate)
    else $error("video before query");
  a_dvi: assert property (p_dvi)
    else $error("dvi flag wrong");
  a_clear: assert property (p_clear)
    else $error("results kept after unplug");

  c_byte: cover property (edid_valid);
  c_done: cover property ($rose(query_done));
  c_cec: cover property ($fell(cec_src_level));
endmodule : hsc_top_properties

bind hsc_top hsc_top_properties #(.TMDS_LANES(TMDS_LANES)) u_props (
  .clock, .reset_n, .sink_enable, .ddc_slave_ready, .sink_presence_assert, .hpd_n_pin,
  .sink_present, .ddc_sda_out, .ddc_sda_oe, .edid_valid, .edid_data, .edid_index,
  .query_done, .dvi_only, .video_enable, .tmds_lane_en, .cec_src_pull_low, .cec_src_in,
  .cec_src_out, .cec_src_oe, .cec_src_level
);

/* File: bench/hsc_top_tb.sv */
// Self-checking bench for the HDMI sideband control block.
`timescale 1ns/10ps

module hsc_top_tb;
  logic clock, reset_n, sink_enable, ddc_slave_ready, hpd_n_pin, mute, sda_pull;
  logic cec_src_pull_low, cec_snk_pull_low, far_src, far_snk;
  logic sink_presence_assert, sink_present, ddc_scl_oe, ddc_sda_oe, edid_valid;
  logic query_done, dvi_only, video_enable, cec_src_oe, cec_src_level, cec_snk_oe;
  logic cec_snk_level;
  logic [7:0] ext_count, edid_data, edid_index;
  logic [3:0] tmds_lane_en;
  logic [15:0] exp_q[$];
  int err_total, cmp_count, n;
  wire scl_w = !ddc_scl_oe;
  wire sda_w = !(ddc_sda_oe || sda_pull);
  wire cec_src_w = !(cec_src_oe || far_src);
  wire cec_snk_w = !(cec_snk_oe || far_snk);

  hsc_top #(.HOLDOFF_CYCLES(4), .QUARTER_CYCLES(6)) uut (
    .clock, .reset_n, .sink_enable, .ddc_slave_ready, .sink_presence_assert, .hpd_n_pin,
    .sink_present, .ddc_scl_in(scl_w), .ddc_scl_out(), .ddc_scl_oe, .ddc_sda_in(sda_w),
    .ddc_sda_out(), .ddc_sda_oe, .edid_valid, .edid_data, .edid_index, .query_done,
    .dvi_only, .video_enable, .tmds_lane_en, .cec_src_pull_low, .cec_src_in(cec_src_w),
    .cec_src_out(), .cec_src_oe, .cec_src_level, .cec_snk_pull_low, .cec_snk_in(cec_snk_w),
    .cec_snk_out(), .cec_snk_oe, .cec_snk_level
  );

  hsc_sink_model u_disp (.scl(scl_w), .sda(sda_w), .mute, .ext_count, .sda_pull);

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Two full capability reads at six clocks a quarter take about 60,000 cycles.
  initial begin
    repeat (80000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  // ================================================================
  // Monitor: each received byte is matched against the oldest note.
  always @(negedge clock) if (edid_valid === 1'b1) begin
    if (exp_q.size() == 0) check("edid_extra", 16'h0001, 16'h0000);
    else check("edid", {edid_index, edid_data}, exp_q.pop_front());
    check("video_early", 16'(video_enable), 16'h0000);
  end

  // ================================================================
  // Driver
  initial begin
    void'($urandom(46));
    {reset_n, sink_enable, ddc_slave_ready, mute} = 4'b0001;
    {cec_src_pull_low, cec_snk_pull_low, far_src, far_snk} = 4'h0;
    hpd_n_pin = 1'b1;
    ext_count = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(negedge clock);
      {sink_enable, ddc_slave_ready} = 2'($urandom);
      @(negedge clock);
      check("presence", 16'(sink_presence_assert), 16'(sink_enable & ddc_slave_ready));
    end
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      {cec_src_pull_low, cec_snk_pull_low, far_src, far_snk} = 4'(i);
      repeat (6) @(negedge clock);
      check("cec_oe", 16'({cec_src_oe, cec_snk_oe}), 16'(i >> 2));
      check("cec_level", 16'({cec_src_level, cec_snk_level}),
            16'({!(i[3] | i[1]), !(i[2] | i[0])}));
    end
    // The first plug has its address phase refused, so the engine has to retry.
    // The second plug flips the extension count so both DVI decisions are taken.
    for (int p = 0; p < 2; p++) begin
      mute = (p == 0);
      ext_count = (p == 0) ? 8'($urandom_range(255, 0)) : 8'(ext_count == 8'h00);
      for (int i = 0; i < 128; i++)
        exp_q.push_back({8'(i), (i == 126) ? ext_count : (8'(i) ^ 8'h5A)});
      check("idle_ddc", 16'({ddc_scl_oe, ddc_sda_oe}), 16'h0000);
      hpd_n_pin = 1'b0;
      repeat (6) @(negedge clock);
      check("present", 16'(sink_present), 16'h0001);
      if (p == 0) begin
        repeat (3000) @(negedge clock);
        check("refused", 16'(exp_q.size()), 16'h0080);
        mute = 1'b0;
      end
      for (n = 0; n < 40000 && query_done !== 1'b1; n++) @(negedge clock);
      check("query_done", 16'(query_done), 16'h0001);
      check("bytes_left", 16'(exp_q.size()), 16'h0000);
      check("dvi", 16'(dvi_only), 16'(ext_count == 8'h00));
      check("video", 16'({video_enable, tmds_lane_en}), 16'h001F);
      hpd_n_pin = 1'b1;
      repeat (6) @(negedge clock);
      check("unplug", 16'({sink_present, query_done, video_enable, ddc_sda_oe}),
            16'h0000);
    end
    wrap_up();
  end
endmodule : hsc_top_tb

/* File: verilog/hsc_map.svh */
// Constants for the HDMI sideband control block: addresses, indices and timing.
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH

// ================================================================
// Clock and DDC timing
`define HSC_CLK_MHZ 25
`define HSC_DDC_QUARTER_NS 2500
`define HSC_DDC_QUARTER_CYC ((`HSC_DDC_QUARTER_NS * `HSC_CLK_MHZ + 999) / 1000)

// ================================================================
// Capability query layout
`define HSC_DDC_ADDR_WR 8'hA0
`define HSC_DDC_ADDR_RD 8'hA1
`define HSC_EDID_OFFSET 8'h00
`define HSC_EDID_BYTES 8'h80
`define HSC_EDID_EXT_IDX 8'h7E

// ================================================================
// Link layout
`define HSC_TMDS_LANES 4

`endif

/* File: verilog/hsc_pkg.sv */
// Types shared by the HDMI sideband control block.
package hsc_pkg;

  // ================================================================
  // Capability query engine states
  typedef enum logic [2:0] {
    HSC_IDLE    = 3'b000,
    HSC_WAIT    = 3'b001,
    HSC_START   = 3'b010,
    HSC_TX      = 3'b011,
    HSC_RESTART = 3'b100,
    HSC_RX      = 3'b101,
    HSC_STOP    = 3'b110,
    HSC_DONE    = 3'b111
  } hsc_state_type;

  // ================================================================
  // Complete register state of the top module
  typedef struct packed {
    hsc_state_type st;
    logic [23:0] wait_cnt;
    logic [7:0] tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [1:0] phase;
    logic [7:0] idx;
    logic [7:0] ext_count;
    logic nack;
    logic fail;
    logic scl_oe;
    logic sda_oe;
    logic edid_valid;
    logic [7:0] edid_data;
    logic [7:0] edid_index;
    logic query_done;
    logic dvi_only;
    logic video_enable;
    logic [3:0] tmds_lane_en;
    logic spa;
    logic cec_src_oe;
    logic cec_snk_oe;
  } hsc_regs_type;

endpackage : hsc_pkg

/* File: verilog/hsc_sync.sv */
// Three-stage input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps

module hsc_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Asynchronous input and clean level
  input wire logic async_in,
  output logic sync_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ================================================================
  // Stages
  // The first stage feeds only the second, so metastability never reaches a decision.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= RESET_VALUE;
      s2_r <= RESET_VALUE;
      s3_r <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end

endmodule : hsc_sync

/* File: verilog/hsc_top.sv */
// HDMI sideband control: sink presence, source capability query and CEC wire drive.
`timescale 1ns/10ps
`include "hsc_map.svh"

module hsc_top #(
  parameter int HOLDOFF_CYCLES = 1024,
  parameter int QUARTER_CYCLES = `HSC_DDC_QUARTER_CYC,
  parameter int TMDS_LANES = `HSC_TMDS_LANES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Sink port presence
  input wire logic sink_enable,
  input wire logic ddc_slave_ready,
  output logic sink_presence_assert,
  // Source port hot-plug, active low at the pin
  input wire logic hpd_n_pin,
  output logic sink_present,
  // Source port DDC, open drain
  input wire logic ddc_scl_in,
  output logic ddc_scl_out,
  output logic ddc_scl_oe,
  input wire logic ddc_sda_in,
  output logic ddc_sda_out,
  output logic ddc_sda_oe,
  // Capability results
  output logic edid_valid,
  output logic [7:0] edid_data,
  output logic [7:0] edid_index,
  output logic query_done,
  output logic dvi_only,
  output logic video_enable,
  output logic [TMDS_LANES-1:0] tmds_lane_en,
  // CEC wires, open drain, one per port
  input wire logic cec_src_pull_low,
  input wire logic cec_src_in,
  output logic cec_src_out,
  output logic cec_src_oe,
  output logic cec_src_level,
  input wire logic cec_snk_pull_low,
  input wire logic cec_snk_in,
  output logic cec_snk_out,
  output logic cec_snk_oe,
  output logic cec_snk_level
);

  localparam logic [7:0] QEND = 8'(QUARTER_CYCLES - 1);
  localparam logic [23:0] HOLD = 24'(HOLDOFF_CYCLES);

  // The synchronisers lag four clocks, so a shorter quarter would sample unsettled data.
  if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES > 32'h00FFFFFF || QUARTER_CYCLES < 32'h00000004 ||
      QUARTER_CYCLES > 32'h00000100 || TMDS_LANES != `HSC_TMDS_LANES) begin : g_bad_params
    $error("hsc_top parameters out of range");
  end

  hsc_pkg::hsc_regs_type s_r;
  hsc_pkg::hsc_regs_type s_nxt;
  logic scl_sync;
  logic sda_sync;
  logic hpd_present;
  logic bit_state;
  logic scl_held;
  logic quarter_end;
  logic adv;

  // ================================================================
  // Pin synchronisers
  hsc_sync #(.RESET_VALUE(1'b0)) u_hpd (
    .clock(clock), .reset_n(reset_n), .async_in(~hpd_n_pin), .sync_out(hpd_present)
  );
  hsc_sync #(.RESET_VALUE(1'b1)) u_scl (
    .clock(clock), .reset_n(reset_n), .async_in(ddc_scl_in), .sync_out(scl_sync)
  );
  hsc_sync #(.RESET_VALUE(1'b1)) u_sda (
    .clock(clock), .reset_n(reset_n), .async_in(ddc_sda_in), .sync_out(sda_sync)
  );
  hsc_sync #(.RESET_VALUE(1'b1)) u_cec_src (
    .clock(clock), .reset_n(reset_n), .async_in(cec_src_in), .sync_out(cec_src_level)
  );
  hsc_sync #(.RESET_VALUE(1'b1)) u_cec_snk (
    .clock(clock), .reset_n(reset_n), .async_in(cec_snk_in), .sync_out(cec_snk_level)
  );

  // ================================================================
  // Line drive for a given engine position
  function automatic logic [1:0] line_pull(input hsc_pkg::hsc_state_type st,
                                           input logic [1:0] q, input logic sda_bit);
    logic scl_low;
    logic sda_low;
    scl_low = 1'b0;
    sda_low = 1'b0;
    unique case (st)
      hsc_pkg::HSC_START: begin
        sda_low = (q >= 2'h2);
        scl_low = (q == 2'h3);
      end
      hsc_pkg::HSC_RESTART: begin
        sda_low = (q >= 2'h2);
        scl_low = (q == 2'h0) || (q == 2'h3);
      end
      hsc_pkg::HSC_TX, hsc_pkg::HSC_RX: begin
        sda_low = ~sda_bit;
        scl_low = (q == 2'h0) || (q == 2'h3);
      end
      hsc_pkg::HSC_STOP: begin
        sda_low = (q <= 2'h1);
        scl_low = (q == 2'h0);
      end
      hsc_pkg::HSC_IDLE, hsc_pkg::HSC_WAIT, hsc_pkg::HSC_DONE: begin
        sda_low = 1'b0;
        scl_low = 1'b0;
      end
    endcase
    return {scl_low, sda_low};
  endfunction : line_pull

  // ================================================================
  // Next state
  always_comb begin
    logic sda_bit;
    logic [1:0] pull;
    sda_bit = 1'b1;
    pull = 2'b00;
    s_nxt = s_r;
    s_nxt.edid_valid = 1'b0;
    s_nxt.spa = sink_enable & ddc_slave_ready;
    s_nxt.cec_src_oe = cec_src_pull_low;
    s_nxt.cec_snk_oe = cec_snk_pull_low;

    bit_state = (s_r.st == hsc_pkg::HSC_START) || (s_r.st == hsc_pkg::HSC_RESTART) ||
                (s_r.st == hsc_pkg::HSC_TX) || (s_r.st == hsc_pkg::HSC_RX) ||
                (s_r.st == hsc_pkg::HSC_STOP);
    // A slave may stretch SCL; the high quarters wait until the wire is really high.
    scl_held = bit_state && ((s_r.q == 2'h1) || (s_r.q == 2'h2)) && !scl_sync;
    quarter_end = (s_r.tick == QEND);
    adv = bit_state && quarter_end && !scl_held;

    if (bit_state) begin
      if (adv) begin
        s_nxt.tick = 8'h00;
        s_nxt.q = s_r.q + 2'h1;
      end else if (!quarter_end) begin
        s_nxt.tick = s_r.tick + 8'h01;
      end
    end

    if (!hpd_present) begin
      // Losing the sink abandons the query; the next plug starts again from the top.
      s_nxt.st = hsc_pkg::HSC_IDLE;
      s_nxt.query_done = 1'b0;
      s_nxt.video_enable = 1'b0;
      s_nxt.dvi_only = 1'b0;
      s_nxt.tick = 8'h00;
      s_nxt.q = 2'h0;
    end else begin
      unique case (s_r.st)
        hsc_pkg::HSC_IDLE: begin
          s_nxt.st = hsc_pkg::HSC_WAIT;
          s_nxt.wait_cnt = 24'h000000;
        end
        hsc_pkg::HSC_WAIT: begin
          s_nxt.wait_cnt = s_r.wait_cnt + 24'h000001;
          if (s_r.wait_cnt == HOLD - 24'h000001) begin
            s_nxt.st = hsc_pkg::HSC_START;
            s_nxt.fail = 1'b0;
            s_nxt.phase = 2'h0;
            s_nxt.idx = 8'h00;
            s_nxt.tick = 8'h00;
            s_nxt.q = 2'h0;
          end
        end
        hsc_pkg::HSC_START, hsc_pkg::HSC_RESTART: begin
          if (adv && s_r.q == 2'h3) begin
            s_nxt.st = hsc_pkg::HSC_TX;
            s_nxt.bitn = 4'h0;
            s_nxt.shreg = (s_r.st == hsc_pkg::HSC_START) ? `HSC_DDC_ADDR_WR : `HSC_DDC_ADDR_RD;
          end
        end
        hsc_pkg::HSC_TX: begin
          if (adv && s_r.q == 2'h2 && s_r.bitn == 4'h8) begin
            s_nxt.nack = sda_sync;
          end
          if (adv && s_r.q == 2'h3) begin
            if (s_r.bitn != 4'h8) begin
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.bitn = s_r.bitn + 4'h1;
            end else if (s_r.nack) begin
              s_nxt.st = hsc_pkg::HSC_STOP;
              s_nxt.fail = 1'b1;
            end else begin
              s_nxt.phase = s_r.phase + 2'h1;
              s_nxt.bitn = 4'h0;
              unique case (s_r.phase)
                2'h0: s_nxt.shreg = `HSC_EDID_OFFSET;
                2'h1: s_nxt.st = hsc_pkg::HSC_RESTART;
                default: s_nxt.st = hsc_pkg::HSC_RX;
              endcase
            end
          end
        end
        hsc_pkg::HSC_RX: begin
          if (adv && s_r.q == 2'h2 && s_r.bitn != 4'h8) begin
            s_nxt.shreg = {s_r.shreg[6:0], sda_sync};
          end
          if (adv && s_r.q == 2'h3) begin
            if (s_r.bitn != 4'h8) begin
              s_nxt.bitn = s_r.bitn + 4'h1;
            end else begin
              s_nxt.edid_valid = 1'b1;
              s_nxt.edid_data = s_r.shreg;
              s_nxt.edid_index = s_r.idx;
              if (s_r.idx == `HSC_EDID_EXT_IDX) begin
                s_nxt.ext_count = s_r.shreg;
              end
              s_nxt.bitn = 4'h0;
              s_nxt.idx = s_r.idx + 8'h01;
              if (s_r.idx == `HSC_EDID_BYTES - 8'h01) begin
                s_nxt.st = hsc_pkg::HSC_STOP;
              end
            end
          end
        end
        hsc_pkg::HSC_STOP: begin
          if (adv && s_r.q == 2'h3) begin
            if (s_r.fail) begin
              s_nxt.st = hsc_pkg::HSC_WAIT;
              s_nxt.wait_cnt = 24'h000000;
            end else begin
              s_nxt.st = hsc_pkg::HSC_DONE;
              s_nxt.query_done = 1'b1;
              s_nxt.dvi_only = (s_r.ext_count == 8'h00);
              s_nxt.video_enable = 1'b1;
            end
          end
        end
        hsc_pkg::HSC_DONE: begin
          s_nxt.st = hsc_pkg::HSC_DONE;
        end
      endcase
    end

    // Bit on SDA: data in TX, release for the slave's ack, master ack in RX but not last.
    if (s_nxt.st == hsc_pkg::HSC_TX) begin
      sda_bit = (s_nxt.bitn == 4'h8) ? 1'b1 : s_nxt.shreg[7];
    end else if (s_nxt.st == hsc_pkg::HSC_RX) begin
      sda_bit = (s_nxt.bitn == 4'h8) ? (s_nxt.idx == `HSC_EDID_BYTES - 8'h01) : 1'b1;
    end
    pull = line_pull(s_nxt.st, s_nxt.q, sda_bit);
    s_nxt.scl_oe = pull[1];
    s_nxt.sda_oe = pull[0];
    s_nxt.tmds_lane_en = {TMDS_LANES{s_nxt.video_enable}};
  end

  // ================================================================
  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ================================================================
  // Outputs
  // Open-drain pins only ever pull low, so their data outputs are fixed at zero.
  assign ddc_scl_out = 1'b0;
  assign ddc_sda_out = 1'b0;
  assign cec_src_out = 1'b0;
  assign cec_snk_out = 1'b0;
  assign ddc_scl_oe = s_r.scl_oe;
  assign ddc_sda_oe = s_r.sda_oe;
  assign cec_src_oe = s_r.cec_src_oe;
  assign cec_snk_oe = s_r.cec_snk_oe;
  assign sink_presence_assert = s_r.spa;
  assign sink_present = hpd_present;
  assign edid_valid = s_r.edid_valid;
  assign edid_data = s_r.edid_data;
  assign edid_index = s_r.edid_index;
  assign query_done = s_r.query_done;
  assign dvi_only = s_r.dvi_only;
  assign video_enable = s_r.video_enable;
  assign tmds_lane_en = s_r.tmds_lane_en;

endmodule : hsc_top
